// [verilog/itc_pkg.sv]
// Package with constants, encodings and carrier types for the instruction timing classifier
//
// Contract
// - Latency counts cycles of dependent micro-op chain.
// - Latencies assume cache hit, no resource contention.
// - Triple latency picks by 16/32/64 operand size.
// - x87 triple latency picks by precision control.
// - Paired latency: register form, memory form parenthesised.
// - Wide LEA: two sources 1, scaled/more 2.
// - Pipe-zero forms schedule only into pipe 0.
// - Pipe-two forms schedule only into pipe 2.
// - No-operation retires using no execution resource.
// - BOUND reg32,mem64 is microcode, latency 6.
// - BTC/BTR/BTS register forms: fast double, latency 2.
// - Near CALL disp: fast double, 3, starred.
// - Decode classes ordered single, double, microcode.
// - Single star marks one-step generation move.
package itc_pkg;

    // ---------------------------------------------------------------
    // Request encodings
    // ---------------------------------------------------------------
    typedef enum logic [4:0] {
        ITC_OP_AAA = 5'h00,
        ITC_OP_AAD = 5'h01,
        ITC_OP_AAM = 5'h02,
        ITC_OP_AAS = 5'h03,
        ITC_OP_ADC = 5'h04,
        ITC_OP_ADD = 5'h05,
        ITC_OP_AND = 5'h06,
        ITC_OP_BOUND = 5'h07,
        ITC_OP_BSF = 5'h08,
        ITC_OP_BSR = 5'h09,
        ITC_OP_BSWAP = 5'h0A,
        ITC_OP_BT = 5'h0B,
        ITC_OP_BTC = 5'h0C,
        ITC_OP_BTR = 5'h0D,
        ITC_OP_BTS = 5'h0E,
        ITC_OP_CALL_DISP = 5'h0F,
        ITC_OP_CALL_REG = 5'h10,
        ITC_OP_CALL_MEM = 5'h11,
        ITC_OP_CBW = 5'h12,
        ITC_OP_CWD = 5'h13,
        ITC_OP_LEA = 5'h14,
        ITC_OP_NOP = 5'h15,
        ITC_OP_IMUL = 5'h16,
        ITC_OP_LZCNT = 5'h17,
        ITC_OP_X87_DIV = 5'h18
    } itc_op_t;

    // Operand source kind of the form
    typedef enum logic [1:0] {
        ITC_SRC_REG = 2'h0,   // Register source / destination
        ITC_SRC_IMM = 2'h1,   // Immediate source, register destination
        ITC_SRC_MEM_DST = 2'h2, // Memory destination
        ITC_SRC_MEM = 2'h3    // Memory source
    } itc_src_t;

    // Operand size selector (also x87 precision control)
    typedef enum logic [1:0] {
        ITC_SZ_16 = 2'h0,
        ITC_SZ_32 = 2'h1,
        ITC_SZ_64 = 2'h2,
        ITC_SZ_8 = 2'h3
    } itc_size_t;

    // Decode class, ordered simplest to most complex
    typedef enum logic [1:0] {
        ITC_DEC_NONE = 2'h0,
        ITC_DEC_FAST_SINGLE = 2'h1,
        ITC_DEC_FAST_DOUBLE = 2'h2,
        ITC_DEC_MICROCODE = 2'h3
    } itc_dec_t;

    // Scheduling restriction
    typedef enum logic [1:0] {
        ITC_PIPE_ANY = 2'h0,
        ITC_PIPE_0 = 2'h1,
        ITC_PIPE_2 = 2'h2,
        ITC_PIPE_NONE = 2'h3  // Occupies no execution pipe
    } itc_pipe_t;

    // ---------------------------------------------------------------
    // Carrier structs
    // ---------------------------------------------------------------
    typedef struct packed {
        itc_op_t op;
        itc_src_t src;
        itc_size_t size;     // Precision control for x87 forms
        logic scaled;        // LEA: scale present or more than two sources
    } itc_req_t;

    typedef struct packed {
        itc_dec_t dec;
        logic [7:0] lat;
        itc_pipe_t pipe;
        logic star;          // One-step easier than prior generation
        logic unsupported;
    } itc_rsp_t;

    // ---------------------------------------------------------------
    // Reset values and fixed latencies
    // ---------------------------------------------------------------
    localparam itc_rsp_t ITC_RSP_RST = '{ITC_DEC_NONE, 8'h00, ITC_PIPE_ANY, 1'b0, 1'b0};
    localparam logic [7:0] ITC_LAT_LEA_TWO = 8'h01;
    localparam logic [7:0] ITC_LAT_LEA_SCALED = 8'h02;
    localparam logic [7:0] ITC_LAT_BOUND = 8'h06;
    localparam logic [7:0] ITC_LAT_BIT_REG = 8'h02;
    localparam logic [7:0] ITC_LAT_CALL_NEAR = 8'h03;
    localparam logic [7:0] ITC_LAT_ANSWER = 8'h01; // Cycles from request to answer

endpackage

// [verilog/itc_classifier.sv]
// Instruction timing classifier: decode class, static latency and pipe restriction lookup
`timescale 1ns/100ps

module itc_classifier
    import itc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Request from dispatch
    input wire logic req_valid,
    input wire itc_req_t req,
    // Answer to dispatch
    output logic rsp_valid_r,
    output itc_rsp_t rsp_r
);

    // ---------------------------------------------------------------
    // Lookup
    // ---------------------------------------------------------------

    itc_rsp_t look; // Combinational table answer
    logic rsp_valid_nxt;
    itc_rsp_t rsp_nxt;

    // Pick one of three values by size or precision
    function automatic logic [7:0] pick3(input itc_size_t s, input logic [7:0] a,
                                         input logic [7:0] b, input logic [7:0] c);
        logic [7:0] v;
        v = a;
        if (s == ITC_SZ_32) begin
            v = b;
        end else if (s == ITC_SZ_64) begin
            v = c;
        end
        return v;
    endfunction

    // Table: latency is the dependent micro-op chain length, ideal conditions
    always_comb begin
        look = '{ITC_DEC_NONE, 8'h00, ITC_PIPE_ANY, 1'b0, 1'b1}; // Unknown by default
        case (req.op)
            ITC_OP_AAA, ITC_OP_AAD, ITC_OP_AAS: begin
                look = '{ITC_DEC_MICROCODE, 8'h05, ITC_PIPE_ANY, 1'b0, 1'b0};
            end
            ITC_OP_AAM: begin
                look = '{ITC_DEC_MICROCODE, 8'h0E, ITC_PIPE_ANY, 1'b0, 1'b0};
            end
            ITC_OP_ADC, ITC_OP_ADD, ITC_OP_AND: begin
                // Register form 1, memory form 4
                look = '{ITC_DEC_FAST_SINGLE, (req.src[1] ? 8'h04 : 8'h01), ITC_PIPE_ANY, 1'b0, 1'b0};
            end
            ITC_OP_BOUND: begin
                // Only reg32, mem64 exists
                if (req.src == ITC_SRC_MEM && req.size == ITC_SZ_32) begin
                    look = '{ITC_DEC_MICROCODE, ITC_LAT_BOUND, ITC_PIPE_ANY, 1'b0, 1'b0};
                end
            end
            ITC_OP_BSF, ITC_OP_BSR: begin
                if (req.src == ITC_SRC_REG || req.src == ITC_SRC_MEM) begin
                    look = '{ITC_DEC_MICROCODE, (req.src[1] ? 8'h07 : 8'h04), ITC_PIPE_ANY, 1'b0, 1'b0};
                end
            end
            ITC_OP_BSWAP, ITC_OP_CBW, ITC_OP_CWD: begin
                if (req.src == ITC_SRC_REG) begin
                    look = '{ITC_DEC_FAST_SINGLE, 8'h01, ITC_PIPE_ANY, 1'b0, 1'b0};
                end
            end
            ITC_OP_BT: begin
                // Memory destination with register index goes to microcode
                if (!req.src[1]) begin
                    look = '{ITC_DEC_FAST_SINGLE, 8'h01, ITC_PIPE_ANY, 1'b0, 1'b0};
                end else if (req.src == ITC_SRC_MEM) begin
                    look = '{ITC_DEC_FAST_SINGLE, 8'h04, ITC_PIPE_ANY, 1'b0, 1'b0};
                end else begin
                    look = '{ITC_DEC_MICROCODE, 8'h07, ITC_PIPE_ANY, 1'b0, 1'b0};
                end
            end
            ITC_OP_BTC, ITC_OP_BTR, ITC_OP_BTS: begin
                if (!req.src[1]) begin
                    look = '{ITC_DEC_FAST_DOUBLE, ITC_LAT_BIT_REG, ITC_PIPE_ANY, 1'b0, 1'b0};
                end else if (req.src == ITC_SRC_MEM) begin
                    look = '{ITC_DEC_MICROCODE, 8'h05, ITC_PIPE_ANY, 1'b0, 1'b0}; // mem, imm
                end else begin
                    look = '{ITC_DEC_MICROCODE, 8'h08, ITC_PIPE_ANY, 1'b0, 1'b0}; // mem, reg
                end
            end
            ITC_OP_CALL_DISP, ITC_OP_CALL_REG: begin
                // Star: one step simpler than prior generation
                look = '{ITC_DEC_FAST_DOUBLE, ITC_LAT_CALL_NEAR, ITC_PIPE_ANY, 1'b1, 1'b0};
            end
            ITC_OP_CALL_MEM: begin
                look = '{ITC_DEC_MICROCODE, 8'h04, ITC_PIPE_ANY, 1'b0, 1'b0};
            end
            ITC_OP_LEA: begin
                if (req.size == ITC_SZ_16) begin
                    look = '{ITC_DEC_MICROCODE, 8'h03, ITC_PIPE_ANY, 1'b0, 1'b0};
                end else if (req.size != ITC_SZ_8) begin
                    look = '{ITC_DEC_FAST_SINGLE, (req.scaled ? ITC_LAT_LEA_SCALED : ITC_LAT_LEA_TWO),
                             ITC_PIPE_ANY, 1'b0, 1'b0};
                end
            end
            ITC_OP_NOP: begin
                look = '{ITC_DEC_FAST_SINGLE, 8'h00, ITC_PIPE_NONE, 1'b0, 1'b0};
            end
            ITC_OP_IMUL: begin
                // Two-operand register and memory-source forms, pipe 0 only 16/32/64 triple
                if (req.src == ITC_SRC_REG && req.size != ITC_SZ_8) begin
                    look = '{ITC_DEC_FAST_SINGLE, pick3(req.size, 8'h03, 8'h03, 8'h04),
                             ITC_PIPE_0, 1'b0, 1'b0};
                end else if (req.src == ITC_SRC_MEM && req.size != ITC_SZ_8) begin
                    look = '{ITC_DEC_FAST_SINGLE, pick3(req.size, 8'h06, 8'h06, 8'h07),
                             ITC_PIPE_0, 1'b0, 1'b0};
                end
            end
            ITC_OP_LZCNT: begin
                if (req.src == ITC_SRC_REG) begin
                    look = '{ITC_DEC_FAST_SINGLE, 8'h02, ITC_PIPE_2, 1'b0, 1'b0};
                end
            end
            ITC_OP_X87_DIV: begin
                // Precision control selects single/double/extended
                if (req.size != ITC_SZ_8) begin
                    look = '{ITC_DEC_FAST_SINGLE, pick3(req.size, 8'h1A, 8'h2A, 8'h4A),
                             ITC_PIPE_ANY, 1'b0, 1'b0};
                end
            end
            default: begin
                look = '{ITC_DEC_NONE, 8'h00, ITC_PIPE_ANY, 1'b0, 1'b1};
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Answer register
    // ---------------------------------------------------------------

    // Next values; held between requests so dispatch may sample late
    always_comb begin
        rsp_valid_nxt = req_valid;
        rsp_nxt = rsp_r;
        if (req_valid) begin
            rsp_nxt = look;
        end
    end

    // Registers only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid_r <= 1'b0;
            rsp_r <= ITC_RSP_RST;
        end else begin
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------

    // A supported answer always carries one of the three ranked classes
    a_class_order: assert property (@(posedge core_clk) disable iff (!rst_b)
        rsp_valid_r && !rsp_r.unsupported |-> rsp_r.dec != ITC_DEC_NONE)
        else $error("supported answer lacks a decode class");
    // A starred entry moved one step, so it can only sit in the middle class
    a_star_step: assert property (@(posedge core_clk) disable iff (!rst_b)
        rsp_valid_r && rsp_r.star |-> rsp_r.dec == ITC_DEC_FAST_DOUBLE)
        else $error("starred answer not in the middle class");
    a_lea_latency: assert property (@(posedge core_clk) disable iff (!rst_b)
        req_valid && req.op == ITC_OP_LEA && req.size inside {ITC_SZ_32, ITC_SZ_64} |=>
            rsp_r.lat == ($past(req.scaled) ? 8'h02 : 8'h01))
        else $error("wide LEA latency wrong");
    a_mul_pipe: assert property (@(posedge core_clk) disable iff (!rst_b)
        rsp_valid_r && !rsp_r.unsupported && $past(req.op) == ITC_OP_IMUL |-> rsp_r.pipe == ITC_PIPE_0)
        else $error("multiply not held to pipe 0");
    a_lzcnt_pipe: assert property (@(posedge core_clk) disable iff (!rst_b)
        req_valid && req.op == ITC_OP_LZCNT && req.src == ITC_SRC_REG |=> rsp_r.pipe == ITC_PIPE_2)
        else $error("leading-zero count not held to pipe 2");
    a_nop_free: assert property (@(posedge core_clk) disable iff (!rst_b)
        req_valid && req.op == ITC_OP_NOP |=> rsp_r.pipe == ITC_PIPE_NONE && rsp_r.lat == 8'h00)
        else $error("no-operation uses a resource");
    a_bound_form: assert property (@(posedge core_clk) disable iff (!rst_b)
        req_valid && req.op == ITC_OP_BOUND && req.src == ITC_SRC_MEM && req.size == ITC_SZ_32
            |=> rsp_r.dec == ITC_DEC_MICROCODE && rsp_r.lat == 8'h06)
        else $error("BOUND class or latency wrong");
    a_bit_reg: assert property (@(posedge core_clk) disable iff (!rst_b)
        req_valid && req.op inside {ITC_OP_BTC, ITC_OP_BTR, ITC_OP_BTS} && !req.src[1]
            |=> rsp_r.dec == ITC_DEC_FAST_DOUBLE && rsp_r.lat == 8'h02)
        else $error("bit modify register form wrong");
    a_call_near: assert property (@(posedge core_clk) disable iff (!rst_b)
        req_valid && req.op == ITC_OP_CALL_DISP
            |=> rsp_r.dec == ITC_DEC_FAST_DOUBLE && rsp_r.lat == 8'h03 && rsp_r.star)
        else $error("near CALL class wrong");
    a_size_pick: assert property (@(posedge core_clk) disable iff (!rst_b)
        req_valid && req.op == ITC_OP_IMUL && req.src == ITC_SRC_REG && req.size == ITC_SZ_64
            |=> rsp_r.lat == 8'h04)
        else $error("64-bit latency not chosen");
    a_unsupported: assert property (@(posedge core_clk) disable iff (!rst_b)
        rsp_valid_r && rsp_r.unsupported |-> rsp_r.dec == ITC_DEC_NONE && rsp_r.lat == 8'h00)
        else $error("unsupported answer carries a class");

endmodule

// [test/itc_dispatch_model.sv]
// Dispatch-side model that issues lookup requests to the classifier
`timescale 1ns/100ps

module itc_dispatch_model
    import itc_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Request toward the classifier
    output logic req_valid,
    output itc_req_t req
);
    // -------------------------------------------------
    // Idle state
    // -------------------------------------------------
    // Idle form is all ones so a stale request never looks like a real one
    initial begin
        req_valid = 1'b0;
        req = '1;
    end

    time rel_time = 0; // Time step in which the strobe last dropped
    bit rel_seen = 1'b0; // Strobe has dropped at least once

    // -------------------------------------------------
    // Request issue
    // -------------------------------------------------
    // Launched at a falling edge, taken at the next rising edge
    task automatic send(input itc_req_t f, input bit last);
        // A strobe dropped in this time step is not raised again before an edge passes
        if (rel_seen && rel_time == $time) begin
            @(negedge core_clk);
        end
        req_valid = 1'b1;
        req = f;
        @(negedge core_clk);
        // Released form is inverted so a held value cannot pass unseen
        if (last) begin
            req_valid = 1'b0;
            req = ~f;
            rel_seen = 1'b1;
            rel_time = $time;
        end
    endtask
endmodule

// [test/instruction_timing_classifier_test.sv]
// Self-checking testbench for the instruction timing classifier
`timescale 1ns/100ps

module instruction_timing_classifier_test
    import itc_pkg::*;
;
    // -------------------------------------------------
    // Signals
    // -------------------------------------------------
    logic core_clk = 1'b0; // 40 MHz core clock
    logic rst_b = 1'b0; // Active-low reset
    logic req_valid; // Driven by the dispatch model
    itc_req_t req; // Request form
    logic rsp_valid_r; // Answer strobe
    itc_rsp_t rsp_r; // Answer
    int failures = 0; // Mismatch count
    int checks_done = 0; // Comparison count

    always #12.5 core_clk = ~core_clk;

    itc_dispatch_model mdl (.core_clk(core_clk), .req_valid(req_valid), .req(req));
    itc_classifier dut (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
        .rsp_valid_r(rsp_valid_r), .rsp_r(rsp_r));

    // -------------------------------------------------
    // Helpers
    // -------------------------------------------------
    // Compare one value, count it, report at once on a mismatch
    task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic itc_req_t mk(itc_op_t o, itc_src_t s, itc_size_t z, logic sc);
        return '{o, s, z, sc};
    endfunction

    function automatic itc_rsp_t rs(itc_dec_t d, logic [7:0] l, itc_pipe_t p, logic st, logic un);
        return '{d, l, p, st, un};
    endfunction

    // Single lookup; the answer strobe stands only in the cycle after the take
    task automatic look(input string what, input itc_req_t f, input itc_rsp_t exp);
        mdl.send(f, 1'b1);
        check(what, {rsp_valid_r, rsp_r}, {1'b1, exp});
    endtask

    // -------------------------------------------------
    // Scenarios
    // -------------------------------------------------
    // Back-to-back wide LEA, then the answer must hold with the strobe low
    task automatic t_lea();
        mdl.send(mk(ITC_OP_LEA, ITC_SRC_MEM, ITC_SZ_32, 1'b0), 1'b0);
        check("lea two", {rsp_valid_r, rsp_r},
            {1'b1, rs(ITC_DEC_FAST_SINGLE, 8'h01, ITC_PIPE_ANY, 0, 0)});
        mdl.send(mk(ITC_OP_LEA, ITC_SRC_MEM, ITC_SZ_64, 1'b1), 1'b1);
        check("lea scaled", {rsp_valid_r, rsp_r},
            {1'b1, rs(ITC_DEC_FAST_SINGLE, 8'h02, ITC_PIPE_ANY, 0, 0)});
        @(negedge core_clk);
        check("lea hold", {rsp_valid_r, rsp_r},
            {1'b0, rs(ITC_DEC_FAST_SINGLE, 8'h02, ITC_PIPE_ANY, 0, 0)});
        look("lea16", mk(ITC_OP_LEA, ITC_SRC_MEM, ITC_SZ_16, 1'b0),
            rs(ITC_DEC_MICROCODE, 8'h03, ITC_PIPE_ANY, 0, 0));
    endtask

    // Fixed entries: bound, bit test and modify forms, near calls
    task automatic t_fixed();
        itc_op_t ops[3] = '{ITC_OP_BTC, ITC_OP_BTR, ITC_OP_BTS};
        look("bound", mk(ITC_OP_BOUND, ITC_SRC_MEM, ITC_SZ_32, 1'b0),
            rs(ITC_DEC_MICROCODE, 8'h06, ITC_PIPE_ANY, 0, 0));
        foreach (ops[i]) begin
            look("bit reg", mk(ops[i], ITC_SRC_REG, ITC_SZ_32, 1'b0),
                rs(ITC_DEC_FAST_DOUBLE, 8'h02, ITC_PIPE_ANY, 0, 0));
            look("bit imm", mk(ops[i], ITC_SRC_IMM, ITC_SZ_64, 1'b0),
                rs(ITC_DEC_FAST_DOUBLE, 8'h02, ITC_PIPE_ANY, 0, 0));
            look("bit mem imm", mk(ops[i], ITC_SRC_MEM, ITC_SZ_32, 1'b0),
                rs(ITC_DEC_MICROCODE, 8'h05, ITC_PIPE_ANY, 0, 0));
            look("bit mem reg", mk(ops[i], ITC_SRC_MEM_DST, ITC_SZ_32, 1'b0),
                rs(ITC_DEC_MICROCODE, 8'h08, ITC_PIPE_ANY, 0, 0));
        end
        look("bt reg", mk(ITC_OP_BT, ITC_SRC_IMM, ITC_SZ_32, 1'b0),
            rs(ITC_DEC_FAST_SINGLE, 8'h01, ITC_PIPE_ANY, 0, 0));
        look("bt mem imm", mk(ITC_OP_BT, ITC_SRC_MEM, ITC_SZ_32, 1'b0),
            rs(ITC_DEC_FAST_SINGLE, 8'h04, ITC_PIPE_ANY, 0, 0));
        look("bt mem reg", mk(ITC_OP_BT, ITC_SRC_MEM_DST, ITC_SZ_32, 1'b0),
            rs(ITC_DEC_MICROCODE, 8'h07, ITC_PIPE_ANY, 0, 0));
        look("call disp", mk(ITC_OP_CALL_DISP, ITC_SRC_IMM, ITC_SZ_64, 1'b0),
            rs(ITC_DEC_FAST_DOUBLE, 8'h03, ITC_PIPE_ANY, 1, 0));
        look("call reg", mk(ITC_OP_CALL_REG, ITC_SRC_REG, ITC_SZ_64, 1'b0),
            rs(ITC_DEC_FAST_DOUBLE, 8'h03, ITC_PIPE_ANY, 1, 0));
        look("call mem", mk(ITC_OP_CALL_MEM, ITC_SRC_MEM, ITC_SZ_64, 1'b0),
            rs(ITC_DEC_MICROCODE, 8'h04, ITC_PIPE_ANY, 0, 0));
    endtask

    // Size-picked and form-picked latencies, pipe restrictions, no-operation
    task automatic t_pick();
        logic [7:0] imul_lat[3] = '{8'h03, 8'h03, 8'h04};
        logic [7:0] imul_mem[3] = '{8'h06, 8'h06, 8'h07};
        logic [7:0] fdiv_lat[3] = '{8'h1A, 8'h2A, 8'h4A};
        for (int i = 0; i < 3; i++) begin
            look("imul rr", mk(ITC_OP_IMUL, ITC_SRC_REG, itc_size_t'(i), 1'b0),
                rs(ITC_DEC_FAST_SINGLE, imul_lat[i], ITC_PIPE_0, 0, 0));
            look("imul rm", mk(ITC_OP_IMUL, ITC_SRC_MEM, itc_size_t'(i), 1'b0),
                rs(ITC_DEC_FAST_SINGLE, imul_mem[i], ITC_PIPE_0, 0, 0));
            mdl.send(mk(ITC_OP_X87_DIV, ITC_SRC_REG, itc_size_t'(i), 1'b0), 1'b1);
            check("x87 lat", {7'h00, rsp_r.lat}, {7'h00, fdiv_lat[i]});
        end
        look("add reg", mk(ITC_OP_ADD, ITC_SRC_IMM, ITC_SZ_32, 1'b0),
            rs(ITC_DEC_FAST_SINGLE, 8'h01, ITC_PIPE_ANY, 0, 0));
        look("add mem", mk(ITC_OP_ADD, ITC_SRC_MEM, ITC_SZ_32, 1'b0),
            rs(ITC_DEC_FAST_SINGLE, 8'h04, ITC_PIPE_ANY, 0, 0));
        look("adc mem dst", mk(ITC_OP_ADC, ITC_SRC_MEM_DST, ITC_SZ_64, 1'b0),
            rs(ITC_DEC_FAST_SINGLE, 8'h04, ITC_PIPE_ANY, 0, 0));
        look("and reg", mk(ITC_OP_AND, ITC_SRC_REG, ITC_SZ_16, 1'b0),
            rs(ITC_DEC_FAST_SINGLE, 8'h01, ITC_PIPE_ANY, 0, 0));
        look("aaa", mk(ITC_OP_AAA, ITC_SRC_REG, ITC_SZ_16, 1'b0),
            rs(ITC_DEC_MICROCODE, 8'h05, ITC_PIPE_ANY, 0, 0));
        look("aam", mk(ITC_OP_AAM, ITC_SRC_REG, ITC_SZ_16, 1'b0),
            rs(ITC_DEC_MICROCODE, 8'h0E, ITC_PIPE_ANY, 0, 0));
        look("bswap", mk(ITC_OP_BSWAP, ITC_SRC_REG, ITC_SZ_32, 1'b0),
            rs(ITC_DEC_FAST_SINGLE, 8'h01, ITC_PIPE_ANY, 0, 0));
        look("cwd", mk(ITC_OP_CWD, ITC_SRC_REG, ITC_SZ_64, 1'b0),
            rs(ITC_DEC_FAST_SINGLE, 8'h01, ITC_PIPE_ANY, 0, 0));
        look("bsf reg", mk(ITC_OP_BSF, ITC_SRC_REG, ITC_SZ_32, 1'b0),
            rs(ITC_DEC_MICROCODE, 8'h04, ITC_PIPE_ANY, 0, 0));
        look("bsf mem", mk(ITC_OP_BSF, ITC_SRC_MEM, ITC_SZ_32, 1'b0),
            rs(ITC_DEC_MICROCODE, 8'h07, ITC_PIPE_ANY, 0, 0));
        look("bsr mem", mk(ITC_OP_BSR, ITC_SRC_MEM, ITC_SZ_64, 1'b0),
            rs(ITC_DEC_MICROCODE, 8'h07, ITC_PIPE_ANY, 0, 0));
        look("lzcnt", mk(ITC_OP_LZCNT, ITC_SRC_REG, ITC_SZ_32, 1'b0),
            rs(ITC_DEC_FAST_SINGLE, 8'h02, ITC_PIPE_2, 0, 0));
        mdl.send(mk(ITC_OP_NOP, ITC_SRC_REG, ITC_SZ_32, 1'b0), 1'b1);
        check("nop pipe", {5'h00, rsp_r.pipe, rsp_r.lat}, {5'h00, ITC_PIPE_NONE, 8'h00});
    endtask

    // Forms outside the table answer unsupported with no class or latency
    task automatic t_unsup();
        itc_req_t bad[8];
        bad[0] = mk(ITC_OP_IMUL, ITC_SRC_REG, ITC_SZ_8, 1'b0);
        bad[1] = mk(ITC_OP_BOUND, ITC_SRC_MEM, ITC_SZ_16, 1'b0);
        bad[2] = mk(itc_op_t'(5'h1F), ITC_SRC_REG, ITC_SZ_32, 1'b0);
        bad[3] = mk(ITC_OP_LEA, ITC_SRC_MEM, ITC_SZ_8, 1'b0);
        bad[4] = mk(ITC_OP_LZCNT, ITC_SRC_MEM, ITC_SZ_32, 1'b0);
        bad[5] = mk(ITC_OP_X87_DIV, ITC_SRC_REG, ITC_SZ_8, 1'b0);
        bad[6] = mk(ITC_OP_BSF, ITC_SRC_MEM_DST, ITC_SZ_32, 1'b0);
        bad[7] = mk(ITC_OP_CBW, ITC_SRC_IMM, ITC_SZ_16, 1'b0);
        foreach (bad[i]) begin
            look("unsupported", bad[i], rs(ITC_DEC_NONE, 8'h00, ITC_PIPE_ANY, 0, 1));
        end
    endtask

    // -------------------------------------------------
    // Verdict and run control
    // -------------------------------------------------
    task automatic report_and_stop();
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog: the tests need well under 200 cycles, so 2000 means a hang
    initial begin
        #(25 * 2000);
        failures++;
        report_and_stop();
    end

    // Main sequence: reset, check reset answer, then each scenario
    initial begin
        repeat (12) @(negedge core_clk);
        check("reset", {rsp_valid_r, rsp_r}, {1'b0, ITC_RSP_RST});
        rst_b = 1'b1;
        @(negedge core_clk);
        t_lea();
        t_fixed();
        t_pick();
        t_unsup();
        report_and_stop();
    end
endmodule
